// [core/pio_pkg.sv]
// Register map, field positions and reset values of the parallel I/O port.
// Assumes a 16-bit register port with one-cycle read latency.
package pio_pkg;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;
	localparam int NPORT = 2;
	localparam int SYNC_W = 4 * DATA_W;
	localparam int THR_W = 5;
	localparam int STRB_W = 3;
	typedef logic [ADDR_W-1:0] pio_addr_t;
	typedef logic [DATA_W-1:0] pio_data_t;
	localparam pio_addr_t A_DATA0 = 5'h00;
	localparam pio_addr_t A_DIR0 = 5'h01;
	localparam pio_addr_t A_OD0 = 5'h02;
	localparam pio_addr_t A_SET0 = 5'h03;
	localparam pio_addr_t A_CLR0 = 5'h04;
	localparam pio_addr_t A_DATA1 = 5'h05;
	localparam pio_addr_t A_DIR1 = 5'h06;
	localparam pio_addr_t A_OD1 = 5'h07;
	localparam pio_addr_t A_INA = 5'h08;
	localparam pio_addr_t A_INB = 5'h09;
	localparam pio_addr_t A_SYSCFG = 5'h0a;
	localparam pio_addr_t A_XPERCFG = 5'h0b;
	localparam pio_addr_t A_THRESH = 5'h0c;
	localparam pio_addr_t A_DRVCTL = 5'h0d;
	localparam pio_addr_t A_STRBDRV = 5'h0e;
	localparam int SYS_EXTENSION_PORT_ENABLE_BIT = 2;
	localparam int XPER_EN_BIT = 3;
	localparam pio_data_t RST_OUT = 16'h0000;
	localparam pio_data_t RST_DIR = 16'h0000;
	localparam pio_data_t RST_OD = 16'h0000;
	localparam pio_data_t RST_CFG = 16'h0000;
	localparam logic [THR_W-1:0] RST_THR = 5'h00;
	localparam logic [STRB_W-1:0] RST_STRB = 3'h0;
endpackage

// [core/pio_port.sv]
// Parallel I/O port: one standard and one extension bidirectional port,
// one standard and one extension input-only port, plus configuration.
// Assumes pin levels are resolved outside from io_out_o and io_oe_o.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// (RULE_01) Every pin is sampled into the input latch each state time.
// (RULE_02) Writing an input pin stores into the output latch, pin not driven.
// (RULE_03) Reading an input pin returns the sampled pin level.
// (RULE_04) Read-modify-write on input pin uses pin level, result goes to latch.
// (RULE_05) Direction bit 1 means writes reach both latch and pin.
// (RULE_06) Reading an output pin returns the output latch.
// (RULE_07) Read-modify-write on output pin uses latch and changes the pin.
// (RULE_08) A pin configured as input is high impedance.
// (RULE_09) Each bidirectional line has a direction bit; input-only ports have none.
// (RULE_10) Per-pin push-pull or open-drain select on bidirectional ports.
// (RULE_11) Open-drain select 0 after reset gives push-pull; 1 gives open-drain.
// (RULE_12) Open-drain latch 1 turns the low driver off; pin floats.
// (RULE_13) Extension ports stay disabled until both enable bits are set.
// (RULE_14) Extension port registers take whole-word access only, no bit operations.
// (RULE_15) Standard port bits can be set, cleared or tested individually.
// (RULE_16) Input threshold control selects hysteresis for five ports.
// (RULE_17) Bus strobe driver control holds ALE, RD and WR driver bits.
// (RULE_18) Peripherals or bus controller may take over port lines.
// (RULE_19) Reset clears all direction bits; all pins start as inputs.
module pio_port (
	input wire logic clock_i, // 20 MHz clock
	input wire logic sys_rst_i, // Synchronous reset, high
	input wire logic clk_en_i, // Freezes all state when low
	input wire pio_pkg::pio_addr_t addr_i, // Register address
	input wire pio_pkg::pio_data_t wdata_i, // Write data
	input wire logic wr_i, // Write strobe
	input wire logic rd_i, // Read strobe
	output logic [pio_pkg::DATA_W-1:0] rdata_o, // Read data, cycle after strobe
	input wire logic [pio_pkg::NPORT-1:0][pio_pkg::DATA_W-1:0] io_pin_i, // Bidir pin levels
	output logic [pio_pkg::NPORT-1:0][pio_pkg::DATA_W-1:0] io_out_o, // Bidir pin drive value
	output logic [pio_pkg::NPORT-1:0][pio_pkg::DATA_W-1:0] io_oe_o, // Bidir pin drive enable
	input wire logic [pio_pkg::NPORT-1:0][pio_pkg::DATA_W-1:0] in_pin_i, // Input-only pins
	input wire logic [pio_pkg::NPORT-1:0][pio_pkg::DATA_W-1:0] alt_en_i, // Peripheral owns line
	input wire logic [pio_pkg::NPORT-1:0][pio_pkg::DATA_W-1:0] alt_out_i, // Peripheral value
	input wire logic [pio_pkg::NPORT-1:0][pio_pkg::DATA_W-1:0] alt_oe_i, // Peripheral enable
	output logic [pio_pkg::THR_W-1:0] thr_sel_o, // Hysteresis select per port
	output logic [pio_pkg::DATA_W-1:0] drv_ctrl_o, // Port output driver control
	output logic [pio_pkg::STRB_W-1:0] strobe_drv_o, // ALE, RD, WR driver select
	output logic ext_en_o // Extension ports enabled
);
	import pio_pkg::*;

	typedef struct packed {
		logic [SYNC_W-1:0] s1;
		logic [SYNC_W-1:0] s2;
		logic [SYNC_W-1:0] s3;
		logic [SYNC_W-1:0] inl;
		logic [NPORT-1:0][DATA_W-1:0] out;
		logic [NPORT-1:0][DATA_W-1:0] dir;
		logic [NPORT-1:0][DATA_W-1:0] od;
		pio_data_t sys_cfg;
		pio_data_t xper_cfg;
		logic [THR_W-1:0] thr;
		pio_data_t drv;
		logic [STRB_W-1:0] strb;
		pio_data_t rdata;
	} pio_state_s;

	pio_state_s st_q;
	pio_state_s st_d;
	logic ext_en;
	logic [NPORT-1:0][DATA_W-1:0] rdval;
	logic [SYNC_W-1:0] agree;

	assign ext_en = st_q.sys_cfg[SYS_EXTENSION_PORT_ENABLE_BIT] & st_q.xper_cfg[XPER_EN_BIT]; // RULE_13
	assign agree = st_q.s2 ~^ st_q.s3;

	// Value seen by a read: latch for outputs, sampled pin for inputs
	always_comb begin
		for (int p = 0; p < NPORT; p++) begin
			rdval[p] = (st_q.out[p] & st_q.dir[p])
				| (st_q.inl[p*DATA_W +: DATA_W] & ~st_q.dir[p]); // RULE_03 RULE_06
		end
	end

	always_comb begin
		st_d = st_q;
		if (clk_en_i) begin
			st_d.s1 = {in_pin_i, io_pin_i};
			st_d.s2 = st_q.s1;
			st_d.s3 = st_q.s2;
			// Accept a level once the last two stages agree
			st_d.inl = (agree & st_q.s3) | (~agree & st_q.inl); // RULE_01
			st_d.rdata = '0;
			if (wr_i) begin
				case (addr_i)
					A_DATA0: st_d.out[0] = wdata_i; // RULE_02 RULE_05
					A_DIR0: st_d.dir[0] = wdata_i; // RULE_09
					A_OD0: st_d.od[0] = wdata_i; // RULE_10
					A_SET0: st_d.out[0] = rdval[0] | wdata_i; // RULE_04 RULE_07 RULE_15
					A_CLR0: st_d.out[0] = rdval[0] & ~wdata_i; // RULE_04 RULE_07 RULE_15
					A_DATA1: begin
						if (ext_en) begin
							st_d.out[1] = wdata_i; // RULE_14
						end
					end
					A_DIR1: begin
						if (ext_en) begin
							st_d.dir[1] = wdata_i;
						end
					end
					A_OD1: begin
						if (ext_en) begin
							st_d.od[1] = wdata_i;
						end
					end
					A_SYSCFG: st_d.sys_cfg = wdata_i;
					A_XPERCFG: st_d.xper_cfg = wdata_i;
					A_THRESH: st_d.thr = wdata_i[THR_W-1:0]; // RULE_16
					A_DRVCTL: st_d.drv = wdata_i;
					A_STRBDRV: st_d.strb = wdata_i[STRB_W-1:0]; // RULE_17
					default: ;
				endcase
			end
			if (rd_i) begin
				case (addr_i)
					A_DATA0: st_d.rdata = rdval[0]; // RULE_03 RULE_06
					A_DIR0: st_d.rdata = st_q.dir[0];
					A_OD0: st_d.rdata = st_q.od[0];
					A_DATA1: st_d.rdata = ext_en ? rdval[1] : '0; // RULE_13
					A_DIR1: st_d.rdata = ext_en ? st_q.dir[1] : '0;
					A_OD1: st_d.rdata = ext_en ? st_q.od[1] : '0;
					A_INA: st_d.rdata = st_q.inl[2*DATA_W +: DATA_W]; // RULE_09
					A_INB: st_d.rdata = ext_en ? st_q.inl[3*DATA_W +: DATA_W] : '0;
					A_SYSCFG: st_d.rdata = st_q.sys_cfg;
					A_XPERCFG: st_d.rdata = st_q.xper_cfg;
					A_THRESH: st_d.rdata = {{(DATA_W-THR_W){1'b0}}, st_q.thr};
					A_DRVCTL: st_d.rdata = st_q.drv;
					A_STRBDRV: st_d.rdata = {{(DATA_W-STRB_W){1'b0}}, st_q.strb};
					default: st_d.rdata = '0;
				endcase
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			st_q.s1 <= '0;
			st_q.s2 <= '0;
			st_q.s3 <= '0;
			st_q.inl <= '0;
			st_q.out <= {NPORT{RST_OUT}};
			st_q.dir <= {NPORT{RST_DIR}}; // RULE_19
			st_q.od <= {NPORT{RST_OD}}; // RULE_11
			st_q.sys_cfg <= RST_CFG;
			st_q.xper_cfg <= RST_CFG;
			st_q.thr <= RST_THR;
			st_q.drv <= RST_CFG;
			st_q.strb <= RST_STRB;
			st_q.rdata <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// Pin drivers; open-drain never drives high, peripherals override except on the extension port while it is disabled
	always_comb begin
		for (int p = 0; p < NPORT; p++) begin
			for (int b = 0; b < DATA_W; b++) begin
				if (alt_en_i[p][b]) begin
					io_out_o[p][b] = alt_out_i[p][b]; // RULE_18
					io_oe_o[p][b] = alt_oe_i[p][b];
				end else begin
					io_out_o[p][b] = st_q.out[p][b] & ~st_q.od[p][b]; // RULE_05 RULE_11
					io_oe_o[p][b] = st_q.dir[p][b] & ~(st_q.od[p][b] & st_q.out[p][b]); // RULE_08 RULE_12
				end
				if (p == 1 && !ext_en) begin
					io_out_o[p][b] = 1'b0; // RULE_13
					io_oe_o[p][b] = 1'b0;
				end
			end
		end
	end

	assign rdata_o = st_q.rdata;
	assign thr_sel_o = st_q.thr; // RULE_16
	assign drv_ctrl_o = st_q.drv;
	assign strobe_drv_o = st_q.strb; // RULE_17
	assign ext_en_o = ext_en;

	chk_dir_reset: assert property (@(posedge clock_i) // RULE_19
		$fell(sys_rst_i) |-> (st_q.dir == '0 && io_oe_o == (alt_en_i & alt_oe_i & {{DATA_W{1'b0}}, {DATA_W{1'b1}}})))
		else $error("direction not cleared by reset");

	chk_input_hiz: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_08
		((io_oe_o[0] & ~st_q.dir[0] & ~alt_en_i[0]) == '0))
		else $error("input pin driven");

	chk_read_value: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_03
		(clk_en_i && rd_i && addr_i == A_DATA0) |=>
		rdata_o == (($past(st_q.out[0]) & $past(st_q.dir[0]))
		| ($past(st_q.inl[DATA_W-1:0]) & ~$past(st_q.dir[0]))))
		else $error("port read value wrong");

	chk_write_latch: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_02
		(clk_en_i && wr_i && addr_i == A_DATA0) |=> st_q.out[0] == $past(wdata_i))
		else $error("output latch not written");

	chk_pushpull_drive: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_05
		((st_q.dir[0] & ~st_q.od[0] & ~alt_en_i[0]
		& ((io_out_o[0] ^ st_q.out[0]) | ~io_oe_o[0])) == '0))
		else $error("push-pull output does not follow latch");

	chk_od_float: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_12
		((st_q.od[0] & st_q.out[0] & ~alt_en_i[0] & io_oe_o[0]) == '0)
		&& ((st_q.od[0] & ~alt_en_i[0] & io_out_o[0]) == '0))
		else $error("open-drain pin driven high");

	chk_set_rmw: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_15
		(clk_en_i && wr_i && addr_i == A_SET0) |=>
		st_q.out[0] == ($past(rdval[0]) | $past(wdata_i)))
		else $error("bit set did not read-modify-write");

	chk_ext_gate: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_13
		!ext_en |-> (io_oe_o[1] == '0 && !ext_en_o))
		else $error("extension port active while disabled");

	chk_sample_pin: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_01
		(clk_en_i && st_q.s2 == st_q.s3) |=> st_q.inl == $past(st_q.s3))
		else $error("pin level not sampled");

	chk_ext_write_drop: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_14
		(clk_en_i && wr_i && addr_i == A_DATA1 && !ext_en) |=> $stable(st_q.out[1]))
		else $error("disabled extension port took a write");

	chk_freeze_state: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_01
		!clk_en_i |=> $stable(st_q))
		else $error("state changed with clock enable low");

	chk_sync_hold: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_01
		clk_en_i |=> ((st_q.inl ^ $past(st_q.inl)) & ~$past(agree)) == '0)
		else $error("unsettled pin level accepted");

	chk_input_read: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_03
		(clk_en_i && rd_i && addr_i == A_DATA0 && st_q.dir[0] == '0) |=>
		rdata_o == $past(st_q.inl[DATA_W-1:0]))
		else $error("input pin read did not return pin level");

	chk_input_rmw: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_04
		(clk_en_i && wr_i && addr_i == A_SET0) |=>
		((st_q.out[0] ^ ($past(st_q.inl[DATA_W-1:0]) | $past(wdata_i)))
		& ~$past(st_q.dir[0])) == '0)
		else $error("input bit modify did not use pin level");

	chk_output_read: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_06
		(clk_en_i && rd_i && addr_i == A_DATA0 && &st_q.dir[0]) |=>
		rdata_o == $past(st_q.out[0]))
		else $error("output pin read did not return latch");

	chk_output_rmw: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_07
		(clk_en_i && wr_i && addr_i == A_SET0) |=>
		((st_q.out[0] ^ ($past(st_q.out[0]) | $past(wdata_i)))
		& $past(st_q.dir[0])) == '0)
		else $error("output bit modify did not use latch");

	chk_dir_write: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_09
		(clk_en_i && wr_i && addr_i == A_DIR0) |=> st_q.dir[0] == $past(wdata_i))
		else $error("direction register not written");

	chk_od_write: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_10
		(clk_en_i && wr_i && addr_i == A_OD0) |=> st_q.od[0] == $past(wdata_i))
		else $error("open-drain select not written");

	chk_od_low_drive: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_11
		((st_q.dir[0] & st_q.od[0] & ~st_q.out[0] & ~alt_en_i[0]
		& (~io_oe_o[0] | io_out_o[0])) == '0))
		else $error("open-drain pin not driven low");

	chk_ina_read: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_09
		(clk_en_i && rd_i && addr_i == A_INA) |=>
		rdata_o == $past(st_q.inl[2*DATA_W +: DATA_W]))
		else $error("input-only port read wrong");

	chk_inb_gate: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_13
		(clk_en_i && rd_i && addr_i == A_INB && !ext_en) |=> rdata_o == '0)
		else $error("disabled extension input read nonzero");

	chk_ext_dir_drop: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_14
		(clk_en_i && wr_i && addr_i == A_DIR1 && !ext_en) |=> $stable(st_q.dir[1]))
		else $error("disabled extension direction took a write");

	chk_port1_drive: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_05
		ext_en |-> ((st_q.dir[1] & ~st_q.od[1] & ~alt_en_i[1]
		& ((io_out_o[1] ^ st_q.out[1]) | ~io_oe_o[1])) == '0))
		else $error("extension output does not follow latch");

	chk_takeover: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_18
		((alt_en_i[0] & ((io_out_o[0] ^ alt_out_i[0]) | (io_oe_o[0] ^ alt_oe_i[0]))) == '0))
		else $error("peripheral takeover not applied");

	chk_thr_write: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_16
		(clk_en_i && wr_i && addr_i == A_THRESH) |=>
		thr_sel_o == $past(wdata_i[THR_W-1:0]))
		else $error("threshold select not written");

	chk_strb_write: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE_17
		(clk_en_i && wr_i && addr_i == A_STRBDRV) |=>
		strobe_drv_o == $past(wdata_i[STRB_W-1:0]))
		else $error("strobe driver select not written");
endmodule

`default_nettype wire

// [verification/pio_pins.sv]
// External circuitry on the bidirectional pins: drivers plus pull-ups.
// Assumes the port drives only where io_oe is high.
`timescale 1ns/1ps
`default_nettype none
module pio_pins
	import pio_pkg::*;
(
	input wire logic [NPORT-1:0][DATA_W-1:0] out_i, // Port drive value
	input wire logic [NPORT-1:0][DATA_W-1:0] oe_i, // Port drive enable
	input wire logic [NPORT-1:0][DATA_W-1:0] ext_val_i, // Outside drive value
	input wire logic [NPORT-1:0][DATA_W-1:0] ext_en_i, // Outside drives line
	output logic [NPORT-1:0][DATA_W-1:0] pin_o // Resolved line level
);
	// Undriven lines float high through the pull-ups
	assign pin_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_val_i) | (~oe_i & ~ext_en_i);
endmodule
`default_nettype wire

// [verification/parallel_io_port_logic_bench.sv]
// Self-checking bench for the parallel I/O port.
// Assumes pio_port and pio_pins; pins resolved by the pull-up model.
`timescale 1ns/1ps
`default_nettype none
module parallel_io_port_logic_bench;
	import pio_pkg::*;
	logic clock_i = 0, sys_rst_i = 1, wr = 0, rd = 0, clk_en = 1;
	pio_addr_t addr = '0;
	pio_data_t wdata = '0;
	logic [DATA_W-1:0] rdata;
	logic [NPORT-1:0][DATA_W-1:0] pin, out, oe, ext_val = '0, ext_en = '0;
	logic [NPORT-1:0][DATA_W-1:0] in_pin = {16'hbeef, 16'hcafe};
	logic [NPORT-1:0][DATA_W-1:0] alt_en = '0, alt_out = '0, alt_oe = '0;
	logic [THR_W-1:0] thr;
	logic [DATA_W-1:0] drv;
	logic [STRB_W-1:0] strb;
	logic ext_on;
	int n_mismatch = 0, n_tests = 0, cyc = 0;
	pio_port pio_port_inst (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en),
		.addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
		.io_pin_i(pin), .io_out_o(out), .io_oe_o(oe), .in_pin_i(in_pin),
		.alt_en_i(alt_en), .alt_out_i(alt_out), .alt_oe_i(alt_oe),
		.thr_sel_o(thr), .drv_ctrl_o(drv), .strobe_drv_o(strb), .ext_en_o(ext_on));
	pio_pins pio_pins_inst (.out_i(out), .oe_i(oe), .ext_val_i(ext_val),
		.ext_en_i(ext_en), .pin_o(pin));
	initial begin
		forever #25 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			summarize();
		end
	end
	task automatic summarize();
		$display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input pio_data_t g, input pio_data_t e);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error at %0t: got %h, expected %h", $time, g, e);
		end
	endtask
	task automatic wrr(input pio_addr_t a, input pio_data_t d);
		@(posedge clock_i);
		wr <= 1;
		addr <= a;
		wdata <= d;
		@(posedge clock_i);
		wr <= 0;
		#1;
	endtask
	task automatic rdc(input pio_addr_t a, input pio_data_t e);
		@(posedge clock_i);
		rd <= 1;
		addr <= a;
		@(posedge clock_i);
		rd <= 0;
		#1;
		chk(rdata, e);
	endtask
	task automatic settle();
		repeat (6) @(posedge clock_i);
	endtask
	task automatic t_reset();
		rdc(A_DIR0, RST_DIR);
		rdc(A_OD0, RST_OD);
		chk(oe[0], 16'h0000);
		rdc(A_INA, 16'hcafe);
	endtask
	task automatic t_input_write();
		ext_en[0] <= 16'hffff;
		ext_val[0] <= 16'ha5a5;
		wrr(A_DATA0, 16'h3c3c);
		settle();
		rdc(A_DATA0, 16'ha5a5);
		chk(oe[0], 16'h0000);
		chk(out[0], 16'h3c3c);
	endtask
	task automatic t_output_rmw();
		wrr(A_DIR0, 16'h00ff);
		chk(oe[0], 16'h00ff);
		chk({8'h00, out[0][7:0]}, 16'h003c);
		rdc(A_DATA0, 16'ha53c);
		wrr(A_SET0, 16'h0101);
		wrr(A_CLR0, 16'h8001);
		chk({8'h00, out[0][7:0]}, 16'h003c);
		wrr(A_DIR0, 16'hffff);
		rdc(A_DATA0, 16'h253c);
	endtask
	task automatic t_open_drain();
		ext_en[0] <= '0;
		wrr(A_OD0, 16'hffff);
		chk(oe[0], 16'hdac3);
		chk(out[0], 16'h0000);
		settle();
		chk(pin[0], 16'h253c);
		rdc(A_DATA0, 16'h253c);
		wrr(A_OD0, 16'h0000);
		chk(oe[0], 16'hffff);
	endtask
	task automatic t_extension();
		wrr(A_DIR1, 16'hffff);
		rdc(A_DIR1, 16'h0000);
		rdc(A_INB, 16'h0000);
		wrr(A_SYSCFG, 16'h0004);
		chk({15'h0, ext_on}, 16'h0000);
		wrr(A_XPERCFG, 16'h0008);
		chk({15'h0, ext_on}, 16'h0001);
		wrr(A_DIR1, 16'hffff);
		wrr(A_DATA1, 16'h1234);
		chk(out[1], 16'h1234);
		chk(oe[1], 16'hffff);
		rdc(A_DIR1, 16'hffff);
		rdc(A_INB, 16'hbeef);
	endtask
	task automatic t_config();
		wrr(A_THRESH, 16'hffff);
		rdc(A_THRESH, 16'h001f);
		chk({11'h0, thr}, 16'h001f);
		wrr(A_STRBDRV, 16'hffff);
		rdc(A_STRBDRV, 16'h0007);
		chk({13'h0, strb}, 16'h0007);
		wrr(A_DRVCTL, 16'h5a5a);
		chk(drv, 16'h5a5a);
		rdc(5'h1f, 16'h0000);
	endtask
	task automatic t_freeze();
		@(posedge clock_i);
		clk_en <= 0;
		wrr(A_DATA0, 16'h0ff0);
		chk(out[0], 16'h253c);
		@(posedge clock_i);
		clk_en <= 1;
		wrr(A_DATA0, 16'h0ff0);
		chk(out[0], 16'h0ff0);
	endtask
	task automatic t_rereset();
		@(posedge clock_i);
		sys_rst_i <= 1;
		repeat (2) @(posedge clock_i);
		sys_rst_i <= 0;
		settle();
		rdc(A_DIR0, RST_DIR);
		chk(oe[0], 16'h0000);
		chk(oe[1], 16'h0000);
		chk({15'h0, ext_on}, 16'h0000);
	endtask
	task automatic t_takeover();
		@(posedge clock_i);
		alt_en[0] <= 16'h0001;
		alt_out[0] <= 16'h0001;
		alt_oe[0] <= 16'h0001;
		@(posedge clock_i);
		#1;
		chk({15'h0, out[0][0]}, 16'h0001);
		chk({15'h0, oe[0][0]}, 16'h0001);
	endtask
	initial begin
		repeat (16) @(posedge clock_i);
		sys_rst_i <= 0;
		settle();
		t_reset();
		t_input_write();
		t_output_rmw();
		t_open_drain();
		t_extension();
		t_config();
		t_freeze();
		t_rereset();
		t_takeover();
		summarize();
	end
endmodule
`default_nettype wire
